// File: sfs_pkg.sv
package sfs_pkg;
  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int PULSE_W_NS    = 320;
  localparam int LEAD_NS       = 760;
  localparam int TMO_US        = 80;
  localparam int PULSE_W_CYC   = (PULSE_W_NS * 1000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam int LEAD_CYC      = (LEAD_NS * 1000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam int TMO_CYC       = (TMO_US * 1000000) / CLK_PERIOD_PS;
  // Window as 90 % .. 110 % of the expected period
  localparam logic [23:0] WIN_LO_NUM = 24'h000009;
  localparam logic [23:0] WIN_HI_NUM = 24'h00000B;
  localparam logic [23:0] WIN_DEN    = 24'h00000A;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [15:0] IDX_CHA    = 16'hFE0A;
  localparam logic [15:0] IDX_CHB    = 16'hFE0B;
  localparam logic [15:0] IDX_CHC    = 16'hFE0C;
  localparam logic [15:0] IDX_REFSEL = 16'hFE0E;
  localparam logic [15:0] IDX_OUTCFG = 16'hFE0F;
  localparam logic [15:0] IDX_CTRL   = 16'hFE10;
  localparam logic [15:0] IDX_PER_A  = 16'hFE11;
  localparam logic [15:0] IDX_PER_B  = 16'hFE12;
  localparam logic [15:0] IDX_PER_C  = 16'hFE13;
  localparam logic [15:0] IDX_STATUS = 16'hFE14;

  // ------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------
  localparam int MULT_LSB    = 6;
  localparam int REF_C_BIT   = 3;
  localparam int OUT_EN_BIT  = 3;
  localparam int CTRL_SYN_FN = 0;
  localparam int CTRL_EN_LSB = 1;
  localparam logic [7:0]  CFG_RST = 8'h00;
  localparam logic [15:0] PER_RST = 16'h0190;

  typedef logic [1:0] sfs_mult_t;
endpackage

// File: sfs_tbase_if.sv
`timescale 1ns/1ps
interface sfs_tbase_if;
  logic [15:0] period;
  logic        enable;
  logic        pulse;
  logic        cycle_start;
  modport ctl (output period, output enable,
               input pulse, input cycle_start);
  modport gen (input period, input enable,
               output pulse, output cycle_start);
endinterface

// File: sfs_sync_gen.sv
`timescale 1ns/1ps
module sfs_sync_gen
  import sfs_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  sfs_tbase_if.gen  tb
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        pulse;
    logic        start;
  } sfs_gen_s;

  sfs_gen_s st_ff;
  sfs_gen_s nxt_st;
  logic [15:0] pulse_at;
  // Lead in cycles, as a plain delay for the checks
  localparam int LEAD_D = LEAD_CYC;

  // ------------------------------------------------------------
  // Reference timebase at the preset period
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    pulse_at = tb.period - 16'(LEAD_CYC);
    nxt_st.start = 1'b0;
    if (!tb.enable) begin
      nxt_st.cnt = '0;
      nxt_st.pulse = 1'b0;
    end else begin
      if (st_ff.cnt >= tb.period - 16'h0001) begin
        nxt_st.cnt = '0;
        nxt_st.start = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
      nxt_st.pulse = (nxt_st.cnt >= pulse_at) &&
                     (nxt_st.cnt < pulse_at + 16'(PULSE_W_CYC));
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tb.pulse = st_ff.pulse;
  assign tb.cycle_start = st_ff.start;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_pulse_13;
    tb.pulse [*8] ##1 tb.pulse [*5];
  endsequence
  property p_width;
    @(posedge clk) disable iff (reset || !tb.enable)
    $rose(tb.pulse) |-> s_pulse_13 ##1 !tb.pulse;
  endproperty
  a_width: assert property (p_width)
    else $error("sync pulse width wrong");
  property p_lead;
    @(posedge clk) disable iff (reset || !tb.enable)
    $rose(tb.pulse) |-> ##LEAD_D tb.cycle_start;
  endproperty
  a_lead: assert property (p_lead)
    else $error("sync pulse lead wrong");
endmodule

// File: sfs_top.sv
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
module sfs_top
  import sfs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        flag_or_sync_in_pin,
  input  wire logic        flag_out_level,
  output logic             flag_or_sync_out_pin,
  output logic             flag_in_level,
  output logic             sync_locked,
  output logic      [2:0]  chan_sync_locked,
  output logic      [19:0] ext_period
);
  typedef struct packed {
    logic [7:0]       cfg_a;
    logic [7:0]       cfg_b;
    logic [7:0]       cfg_c;
    logic [7:0]       refsel;
    logic [7:0]       outcfg;
    logic [3:0]       ctrl;
    logic [15:0]      per_a;
    logic [15:0]      per_b;
    logic [15:0]      per_c;
    logic [2:0]       sync_in;
    logic             in_lvl;
    logic [19:0]      cnt;
    logic             have_edge;
    logic             locked;
    logic [2:0]       lock_ch;
    logic [19:0]      meas;
    logic             pin;
    logic [31:0]      rdata;
  } sfs_top_s;

  sfs_top_s    st_ff;
  sfs_top_s    nxt_st;
  sfs_tbase_if tb ();

  logic        acc;
  logic [15:0] idx;
  logic        hit;
  logic [2:0]  en;
  logic [1:0]  sel;
  sfs_mult_t   best;
  logic [15:0] sel_per;
  logic [19:0] expect_per;
  logic [23:0] lo_b;
  logic [23:0] hi_b;
  logic        edge_det;
  logic        sync_fn;
  logic        in_win;

  sfs_sync_gen u_gen (
    .clk   (clk),
    .reset (reset),
    .tb    (tb)
  );

  // ------------------------------------------------------------
  // Reference selection and expected window
  // ------------------------------------------------------------
  assign sync_fn = st_ff.ctrl[CTRL_SYN_FN];
  assign en = st_ff.ctrl[CTRL_EN_LSB +: 3];
  assign tb.period = st_ff.refsel[REF_C_BIT] ? st_ff.per_c : st_ff.per_a;
  assign tb.enable = st_ff.outcfg[OUT_EN_BIT];

  always_comb begin
    sel = 2'h0;
    best = st_ff.cfg_a[MULT_LSB +: 2];
    sel_per = st_ff.per_a;
    if (!en[0] || (en[1] && st_ff.cfg_b[MULT_LSB +: 2] < best)) begin
      if (en[1]) begin
        sel = 2'h1;
        best = st_ff.cfg_b[MULT_LSB +: 2];
        sel_per = st_ff.per_b;
      end
    end
    if (en[2] && ((en[0] || en[1]) == 1'b0 ||
                  st_ff.cfg_c[MULT_LSB +: 2] < best)) begin
      sel = 2'h2;
      best = st_ff.cfg_c[MULT_LSB +: 2];
      sel_per = st_ff.per_c;
    end
  end

  assign expect_per = {4'h0, sel_per} << best;
  assign lo_b = ({4'h0, expect_per} * WIN_LO_NUM) / WIN_DEN;
  assign hi_b = ({4'h0, expect_per} * WIN_HI_NUM) / WIN_DEN;
  assign in_win = ({4'h0, st_ff.cnt} >= lo_b) &&
                  ({4'h0, st_ff.cnt} <= hi_b);

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign acc = psel && penable;
  assign idx = paddr[17:2];
  assign hit = (idx == IDX_CHA) || (idx == IDX_CHB) ||
               (idx == IDX_CHC) || (idx == IDX_REFSEL) ||
               (idx == IDX_OUTCFG) || (idx == IDX_CTRL) ||
               (idx == IDX_PER_A) || (idx == IDX_PER_B) ||
               (idx == IDX_PER_C) || (idx == IDX_STATUS);

  assign edge_det = !st_ff.in_lvl && st_ff.sync_in[1] && st_ff.sync_in[2];

  always_comb begin
    nxt_st = st_ff;
    if (acc && pwrite) begin
      if (idx == IDX_CHA) begin
        nxt_st.cfg_a = pwdata[7:0];
      end else if (idx == IDX_CHB) begin
        nxt_st.cfg_b = pwdata[7:0];
      end else if (idx == IDX_CHC) begin
        nxt_st.cfg_c = pwdata[7:0];
      end else if (idx == IDX_REFSEL) begin
        nxt_st.refsel = pwdata[7:0];
      end else if (idx == IDX_OUTCFG) begin
        nxt_st.outcfg = pwdata[7:0];
      end else if (idx == IDX_CTRL) begin
        nxt_st.ctrl = pwdata[3:0];
      end else if (idx == IDX_PER_A) begin
        nxt_st.per_a = pwdata[15:0];
      end else if (idx == IDX_PER_B) begin
        nxt_st.per_b = pwdata[15:0];
      end else if (idx == IDX_PER_C) begin
        nxt_st.per_c = pwdata[15:0];
      end
    end
    nxt_st.rdata = '0;
    if (psel && !penable && !pwrite) begin
      if (idx == IDX_CHA) begin
        nxt_st.rdata = {24'h000000, st_ff.cfg_a};
      end else if (idx == IDX_CHB) begin
        nxt_st.rdata = {24'h000000, st_ff.cfg_b};
      end else if (idx == IDX_CHC) begin
        nxt_st.rdata = {24'h000000, st_ff.cfg_c};
      end else if (idx == IDX_REFSEL) begin
        nxt_st.rdata = {24'h000000, st_ff.refsel};
      end else if (idx == IDX_OUTCFG) begin
        nxt_st.rdata = {24'h000000, st_ff.outcfg};
      end else if (idx == IDX_CTRL) begin
        nxt_st.rdata = {28'h0000000, st_ff.ctrl};
      end else if (idx == IDX_PER_A) begin
        nxt_st.rdata = {16'h0000, st_ff.per_a};
      end else if (idx == IDX_PER_B) begin
        nxt_st.rdata = {16'h0000, st_ff.per_b};
      end else if (idx == IDX_PER_C) begin
        nxt_st.rdata = {16'h0000, st_ff.per_c};
      end else if (idx == IDX_STATUS) begin
        nxt_st.rdata = {st_ff.meas, 6'h00, sel, st_ff.lock_ch,
                        st_ff.locked};
      end
    end

    nxt_st.sync_in = {st_ff.sync_in[1:0], flag_or_sync_in_pin};
    if (st_ff.sync_in[1] == st_ff.sync_in[2]) begin
      nxt_st.in_lvl = st_ff.sync_in[2];
    end

    if (edge_det) begin
      // Edge cycle counts as the first cycle of the new interval
      nxt_st.cnt = 20'h00001;
      nxt_st.have_edge = 1'b1;
      nxt_st.meas = st_ff.cnt;
      if (st_ff.have_edge) begin
        nxt_st.locked = in_win && (en != 3'h0);
      end
    end else begin
      if (st_ff.cnt != 20'hFFFFF) begin
        nxt_st.cnt = st_ff.cnt + 20'h00001;
      end
      if (st_ff.cnt >= 20'(TMO_CYC)) begin
        nxt_st.locked = 1'b0;
        nxt_st.have_edge = 1'b0;
      end
    end
    if (!sync_fn) begin
      nxt_st.locked = 1'b0;
      nxt_st.have_edge = 1'b0;
    end
    nxt_st.lock_ch = nxt_st.locked ? en : 3'h0;

    nxt_st.pin = st_ff.outcfg[OUT_EN_BIT] ? tb.pulse : flag_out_level;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.per_a <= PER_RST;
      st_ff.per_b <= PER_RST;
      st_ff.per_c <= PER_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign flag_or_sync_out_pin = st_ff.pin;
  assign flag_in_level = sync_fn ? 1'b0 : st_ff.in_lvl;
  assign sync_locked = st_ff.locked;
  assign chan_sync_locked = st_ff.lock_ch;
  assign ext_period = st_ff.meas;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_pin;
    @(posedge clk) disable iff (reset)
    st_ff.outcfg[OUT_EN_BIT] && tb.pulse |=> flag_or_sync_out_pin;
  endproperty
  a_pin: assert property (p_pin)
    else $error("sync pulse missing on pin");
  property p_accept;
    @(posedge clk) disable iff (reset)
    edge_det && st_ff.have_edge && in_win && sync_fn && en != 3'h0
      |=> sync_locked;
  endproperty
  a_accept: assert property (p_accept)
    else $error("in-window edge not accepted");
  property p_reject;
    @(posedge clk) disable iff (reset)
    edge_det && st_ff.have_edge && !in_win |=> !sync_locked;
  endproperty
  a_reject: assert property (p_reject)
    else $error("out-of-window edge kept lock");
  property p_timeout;
    @(posedge clk) disable iff (reset)
    !edge_det && st_ff.cnt == 20'(TMO_CYC) |=> !sync_locked;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not drop lock");
  property p_flagfn;
    @(posedge clk) disable iff (reset)
    !sync_fn |=> !sync_locked && chan_sync_locked == 3'h0;
  endproperty
  a_flagfn: assert property (p_flagfn)
    else $error("lock held in flag function");
  property p_prio;
    @(posedge clk) disable iff (reset)
    en[0] && st_ff.cfg_a[MULT_LSB +: 2] == 2'h0 |-> sel == 2'h0;
  endproperty
  a_prio: assert property (p_prio)
    else $error("channel A lost priority");
  property p_meas;
    @(posedge clk) disable iff (reset)
    edge_det |=> st_ff.cnt == 20'h00001 && ext_period == $past(st_ff.cnt);
  endproperty
  a_meas: assert property (p_meas)
    else $error("edge interval not captured");
endmodule

// File: sfs_sync_src.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// External sync clock source, held low while stopped
// ------------------------------------------------------------
module sfs_sync_src (
  input  wire logic        run,
  input  wire logic [31:0] period_ns,
  output logic             pin
);
  logic [31:0] per;
  initial begin
    pin = 1'b0;
    forever begin
      wait (run === 1'b1);
      // Keeps edges off the bench clock edges
      #7;
      while (run === 1'b1) begin
        per = (period_ns < 32'h641) ? 32'h641 : period_ns;
        pin = 1'b1;
        #(per / 2);
        pin = 1'b0;
        #(per - per / 2);
      end
    end
  end
endmodule

// File: switching_frequency_sync_test.sv
`timescale 1ns/1ps
module switching_frequency_sync_test;
  import sfs_pkg::*;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, period_ns, d;
  logic        pin_in, flag_out_level, pin_out, flag_in_level, e;
  logic        sync_locked, run;
  logic [2:0]  chan_sync_locked;
  logic [19:0] ext_period;
  int          error_cnt, check_count, hi, per, m;

  sfs_top dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flag_or_sync_in_pin(pin_in),
    .flag_out_level(flag_out_level), .flag_or_sync_out_pin(pin_out),
    .flag_in_level(flag_in_level), .sync_locked(sync_locked),
    .chan_sync_locked(chan_sync_locked), .ext_period(ext_period));
  sfs_sync_src src_u (.run(run), .period_ns(period_ns), .pin(pin_in));

  always #12.5 clk = ~clk;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic hang;
    error_cnt++;
    summarize;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) hang;
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_lock(input logic ex, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(negedge clk);
      if (sync_locked === ex) break;
    end
    check(32'(sync_locked), 32'(ex));
    if (n == lim) hang;
  endtask

  task automatic try_win(input int cyc, input logic ex, input logic pv);
    @(posedge clk);
    run <= 1'b0;
    wait_lock(1'b0, 3600);
    @(posedge clk);
    period_ns <= 32'(cyc * 25);
    run <= 1'b1;
    repeat (1500) @(negedge clk);
    check(32'(sync_locked), 32'(ex));
    if (pv) check(32'(ext_period), 32'(cyc));
  endtask

  task automatic meas;
    int n;
    logic s, pv;
    hi = 0;
    per = 0;
    s = 1'b0;
    pv = 1'b1;
    for (n = 0; n < 3000; n++) begin
      @(negedge clk);
      if (pin_out === 1'b1 && pv === 1'b0) begin
        if (s) break;
        s = 1'b1;
      end
      if (s) per++;
      if (s && pin_out === 1'b1) hi++;
      pv = pin_out;
    end
    if (n == 3000) hang;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, IDX_PER_A, 32'h0);
    check(d, 32'h190);
    apb(1'b1, IDX_CHA, 32'hC0);
    apb(1'b0, IDX_CHA, 32'h0);
    check(d, 32'hC0);
    apb(1'b0, 16'hFE0D, 32'h0);
    check(32'(e), 32'h1);
  endtask

  task automatic t_out;
    apb(1'b1, IDX_PER_A, 32'd100);
    apb(1'b1, IDX_PER_C, 32'd60);
    apb(1'b1, IDX_REFSEL, 32'h0);
    apb(1'b1, IDX_OUTCFG, 32'h8);
    meas;
    check(32'(hi), 32'(PULSE_W_CYC));
    check(32'(per), 32'd100);
    // Park the timebase so the new period starts from a clean count
    apb(1'b1, IDX_OUTCFG, 32'h0);
    apb(1'b1, IDX_REFSEL, 32'h8);
    apb(1'b1, IDX_OUTCFG, 32'h8);
    meas;
    check(32'(hi), 32'(PULSE_W_CYC));
    check(32'(per), 32'd60);
    apb(1'b1, IDX_OUTCFG, 32'h0);
    @(posedge clk);
    flag_out_level <= 1'b1;
    repeat (3) @(negedge clk);
    check(32'(pin_out), 32'h1);
  endtask

  task automatic t_lock;
    apb(1'b1, IDX_PER_A, 32'd400);
    apb(1'b1, IDX_CHA, 32'h0);
    apb(1'b1, IDX_REFSEL, 32'h0);
    apb(1'b1, IDX_OUTCFG, 32'h8);
    apb(1'b1, IDX_CTRL, 32'h3);
    try_win(440, 1'b1, 1'b1);
    try_win(360, 1'b1, 1'b1);
    try_win(441, 1'b0, 1'b1);
    try_win(359, 1'b0, 1'b1);
    try_win(420, 1'b1, 1'b1);
    check(32'(chan_sync_locked), 32'h1);
    meas;
    check(32'(per), 32'd400);
    @(posedge clk);
    run <= 1'b0;
    repeat (2700) @(negedge clk);
    check(32'(sync_locked), 32'h1);
    wait_lock(1'b0, 700);
  endtask

  task automatic t_prio;
    // Periods change below; park the timebase first
    apb(1'b1, IDX_OUTCFG, 32'h0);
    apb(1'b1, IDX_CHA, 32'h40);
    apb(1'b1, IDX_CHB, 32'h0);
    apb(1'b1, IDX_PER_B, 32'd300);
    apb(1'b1, IDX_CTRL, 32'h7);
    try_win(300, 1'b1, 1'b1);
    check(32'(chan_sync_locked), 32'h3);
    apb(1'b0, IDX_STATUS, 32'h0);
    check(32'(d[5:4]), 32'h1);
    apb(1'b1, IDX_CHA, 32'h0);
    apb(1'b1, IDX_CHC, 32'h0);
    apb(1'b1, IDX_PER_C, 32'd300);
    apb(1'b1, IDX_CTRL, 32'hB);
    try_win(400, 1'b1, 1'b1);
    apb(1'b0, IDX_STATUS, 32'h0);
    check(32'(d[5:4]), 32'h0);
    apb(1'b1, IDX_CTRL, 32'h3);
    for (m = 0; m < 4; m++) begin
      apb(1'b1, IDX_CHA, 32'(m << 6));
      apb(1'b1, IDX_PER_A, 32'(400 >> m));
      try_win(400, 1'b1, 1'b1);
    end
  endtask

  task automatic t_flag;
    int n;
    apb(1'b1, IDX_CHA, 32'h0);
    apb(1'b1, IDX_PER_A, 32'd400);
    apb(1'b1, IDX_CTRL, 32'h2);
    try_win(400, 1'b0, 1'b0);
    for (n = 0; n < 500; n++) begin
      @(negedge clk);
      if (flag_in_level === 1'b1) break;
    end
    if (n == 500) hang;
    check(32'(flag_in_level), 32'h1);
    apb(1'b1, IDX_CTRL, 32'h3);
    repeat (2) @(negedge clk);
    check(32'(flag_in_level), 32'h0);
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    flag_out_level = 1'b0;
    run = 1'b0;
    period_ns = 32'h2710;
    error_cnt = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_out;
    t_lock;
    t_prio;
    t_flag;
    summarize;
  end
endmodule
